// >>> design/asalu_pkg.sv
// package for the add/and/shift datapath: operation codes, field
// positions, register port map and the carrier structs.
// assumes the decoder hands over one operation word per exec strobe.
//
// Behaviour
// RULE1: the pointer add sign-extends a 6-bit literal (-32 to 31), adds it to the selected 16-bit pointer pair 0 or 1, writes the sum back and leaves every flag alone.
// RULE2: the 16-bit indirect pointer stays within 0000h-FFFFh and wraps modulo 65536 instead of saturating.
// RULE3: the literal AND puts the accumulator ANDed with an 8-bit literal into the accumulator and changes only the zero flag.
// RULE4: the literal add puts the accumulator plus an 8-bit literal into the accumulator and updates carry, half carry and zero.
// RULE5: the register AND combines the accumulator with the file register at a 7-bit address (0 to 127) and changes only the zero flag.
// RULE6: a register-operand result goes to the accumulator when the destination bit is 0 and back to the file register when it is 1.
// RULE7: the register add sums accumulator and file register into the chosen destination and updates carry, half carry and zero.
// RULE8: the arithmetic right shift keeps bit 7, moves bits 7:1 into bits 6:0, loads bit 0 into carry and updates zero.
// RULE9: the add with carry sums accumulator, file register and carry into the chosen destination and updates carry, half carry and zero.
// RULE10: the pointer add is decoded from a 14-bit word whose top bits are 11 0001 0, followed by the pointer select bit and six literal bits.
// RULE11: zero is set when the 8-bit result is zero, carry is the carry out of bit 7 and half carry the carry out of bit 3.
package asalu_pkg;

   // operation select from the decoder; none lets the word decode itself
   typedef enum logic [2:0] {
      ASALU_OP_NONE = 3'h0,
      ASALU_OP_LAND = 3'h1,
      ASALU_OP_LADD = 3'h2,
      ASALU_OP_RAND = 3'h3,
      ASALU_OP_RADD = 3'h4,
      ASALU_OP_ASR  = 3'h5,
      ASALU_OP_ADDC = 3'h6
   } asalu_op_t;

   // instruction word fields
   localparam int INSTR_W = 14;
   localparam int PTRADD_TOP_MSB = 13;
   localparam int PTRADD_TOP_LSB = 7;
   localparam logic [6:0] PTRADD_PATTERN = 7'h62;
   localparam int PTR_SEL_BIT = 6;
   localparam int PTR_LIT_MSB = 5;
   localparam int DEST_BIT = 7;
   localparam int FADDR_MSB = 6;
   localparam int LIT_MSB = 7;

   // register port map, 2-bit word index
   localparam logic [1:0] REG_ACC = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_PTR0 = 2'h2;
   localparam logic [1:0] REG_PTR1 = 2'h3;
   localparam int STAT_C_BIT = 0;
   localparam int STAT_DC_BIT = 1;
   localparam int STAT_Z_BIT = 2;

   // reset values
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [15:0] PTR_RESET = 16'h0000;

   typedef struct packed {
      asalu_op_t op;
      logic [INSTR_W-1:0] instr;
      logic [7:0] fdata;
   } asalu_req_t;

   typedef struct packed {
      logic [7:0] acc;
      logic c;
      logic dc;
      logic z;
      logic [1:0][15:0] ptr;
      logic fwr;
      logic [6:0] fwr_addr;
      logic [7:0] fwr_data;
      logic [15:0] rdata;
   } asalu_state_t;

endpackage

// >>> design/asalu_add8.sv
// 8-bit adder with carry in, carry out of bit 7 and of bit 3.
// assumes pure combinational use inside the datapath.
`timescale 1ns/1ps
module asalu_add8 (
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   output logic [7:0] sum_o,
   output logic c_o,
   output logic dc_o
);
   logic [4:0] lo;
   logic [4:0] hi;

   always_comb begin
      lo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
      hi = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, lo[4]};
      sum_o = {hi[3:0], lo[3:0]};
      c_o = hi[4]; // RULE11
      dc_o = lo[4]; // RULE11
   end
endmodule

// >>> design/asalu_core.sv
// add/and/shift datapath: accumulator, two indirect pointer pairs,
// carry, half carry and zero flags, file register write-back port.
// assumes fdata in the request already holds the addressed file register.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module asalu_core (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic exec_i,
   input wire asalu_pkg::asalu_req_t req_i,
   input wire logic [1:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   output logic [7:0] acc_o,
   output logic carry_o,
   output logic half_carry_o,
   output logic zero_o,
   output logic fwr_o,
   output logic [6:0] fwr_addr_o,
   output logic [7:0] fwr_data_o
);
   import asalu_pkg::*;

   asalu_state_t q;
   asalu_state_t d;

   logic [7:0] lit;
   logic [6:0] faddr;
   logic dest_file;
   logic ptr_sel;
   logic is_ptradd;
   logic reg_op;
   logic [7:0] opnd;
   logic cin;
   logic [7:0] sum;
   logic add_c;
   logic add_dc;
   logic [7:0] res;
   logic stat_wr;
   logic acc_wr;
   logic c_keep;
   logic dc_keep;

   function automatic logic [15:0] sext6(input logic [5:0] k);
      return {{10{k[5]}}, k};
   endfunction

   function automatic logic is_reg_op(input asalu_op_t op);
      return op inside {ASALU_OP_RAND, ASALU_OP_RADD, ASALU_OP_ASR,
                        ASALU_OP_ADDC};
   endfunction

   assign lit = req_i.instr[LIT_MSB:0];
   assign faddr = req_i.instr[FADDR_MSB:0]; // RULE5
   assign dest_file = req_i.instr[DEST_BIT];
   assign ptr_sel = req_i.instr[PTR_SEL_BIT];
   assign is_ptradd = (req_i.op == ASALU_OP_NONE) &&
      (req_i.instr[PTRADD_TOP_MSB:PTRADD_TOP_LSB] == PTRADD_PATTERN); // RULE10
   assign reg_op = is_reg_op(req_i.op);
   assign opnd = reg_op ? req_i.fdata : lit;
   assign cin = (req_i.op == ASALU_OP_ADDC) ? q.c : 1'b0; // RULE9
   // flags that survive an operation leaving them alone: a same-cycle
   // status write still lands on them
   assign stat_wr = reg_wr_i && (reg_addr_i == REG_STATUS);
   assign acc_wr = reg_wr_i && (reg_addr_i == REG_ACC);
   assign c_keep = stat_wr ? reg_wdata_i[STAT_C_BIT] : q.c;
   assign dc_keep = stat_wr ? reg_wdata_i[STAT_DC_BIT] : q.dc;

   asalu_add8 u_add (
      .a_i(q.acc),
      .b_i(opnd),
      .cin_i(cin),
      .sum_o(sum),
      .c_o(add_c),
      .dc_o(add_dc)
   );

   always_comb begin
      d = q;
      d.fwr = 1'b0;
      d.rdata = 16'h0000;
      res = 8'h00;
      // software access first so that a same-cycle operation wins
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            REG_ACC: d.acc = reg_wdata_i[7:0];
            REG_STATUS: begin
               d.c = reg_wdata_i[STAT_C_BIT];
               d.dc = reg_wdata_i[STAT_DC_BIT];
               d.z = reg_wdata_i[STAT_Z_BIT];
            end
            REG_PTR0: d.ptr[0] = reg_wdata_i;
            REG_PTR1: d.ptr[1] = reg_wdata_i;
         endcase
      end
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            REG_ACC: d.rdata = {8'h00, q.acc};
            REG_STATUS: d.rdata = {13'h0, q.z, q.dc, q.c};
            REG_PTR0: d.rdata = q.ptr[0];
            REG_PTR1: d.rdata = q.ptr[1];
         endcase
      end
      if (exec_i) begin
         unique case (req_i.op)
            ASALU_OP_NONE: begin
               if (is_ptradd) begin
                  // 16-bit sum drops the carry: wraps, no saturation
                  d.ptr[ptr_sel] = q.ptr[ptr_sel] +
                     sext6(req_i.instr[PTR_LIT_MSB:0]); // RULE1 RULE2
               end
            end
            ASALU_OP_LAND, ASALU_OP_RAND: begin
               res = q.acc & opnd; // RULE3 RULE5
               d.z = (res == 8'h00); // RULE11
            end
            ASALU_OP_LADD, ASALU_OP_RADD, ASALU_OP_ADDC: begin
               res = sum; // RULE4 RULE7 RULE9
               d.c = add_c;
               d.dc = add_dc;
               d.z = (res == 8'h00); // RULE11
            end
            ASALU_OP_ASR: begin
               res = {req_i.fdata[7], req_i.fdata[7:1]}; // RULE8
               d.c = req_i.fdata[0]; // RULE8
               d.z = (res == 8'h00); // RULE8
            end
            default: res = 8'h00;
         endcase
         if (req_i.op != ASALU_OP_NONE) begin
            if (reg_op && dest_file) begin
               d.fwr = 1'b1; // RULE6
               d.fwr_addr = faddr;
               d.fwr_data = res;
            end else begin
               d.acc = res; // RULE6
            end
         end
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.acc <= ACC_RESET;
         q.ptr <= {PTR_RESET, PTR_RESET};
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_o = q.rdata;
   assign acc_o = q.acc;
   assign carry_o = q.c;
   assign half_carry_o = q.dc;
   assign zero_o = q.z;
   assign fwr_o = q.fwr;
   assign fwr_addr_o = q.fwr_addr;
   assign fwr_data_o = q.fwr_data;

   // checks, all on the registered state one edge after an operation

   sequence ptradd_s(logic n);
      exec_i && is_ptradd && (ptr_sel == n);
   endsequence

   property ptr_sum_p(logic n);
      @(posedge mclk_i) disable iff (sys_rst_i)
      ptradd_s(n) |=> q.ptr[n] ==
         16'($past(q.ptr[n]) + sext6($past(req_i.instr[PTR_LIT_MSB:0])));
   endproperty

   ptr0_sum_a: assert property (ptr_sum_p(1'b0)) // RULE1
      else $error("pointer 0 sum wrong");

   ptr1_wrap_a: assert property (ptr_sum_p(1'b1)) // RULE2
      else $error("pointer 1 sum or wrap wrong");

   ptr_flags_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && is_ptradd && !reg_wr_i |=> $stable(q.c) && $stable(q.dc)
      && $stable(q.z) && $stable(q.acc)) // RULE1
      else $error("pointer add touched flags or accumulator");

   lit_and_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_LAND |=>
      acc_o == ($past(q.acc) & $past(lit)) && carry_o == $past(c_keep)
      && half_carry_o == $past(dc_keep)) // RULE3
      else $error("literal and result or flags wrong");

   lit_add_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_LADD |=>
      {carry_o, acc_o} == 9'($past(q.acc) + $past(lit))) // RULE4
      else $error("literal add result or carry wrong");

   reg_and_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_RAND && !dest_file |=>
      acc_o == ($past(q.acc) & $past(req_i.fdata))
      && carry_o == $past(c_keep)) // RULE5
      else $error("register and result wrong");

   dest_file_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && reg_op && dest_file && !reg_wr_i |=>
      fwr_o && fwr_addr_o == $past(faddr) && $stable(q.acc)) // RULE6
      else $error("file destination not honoured");

   reg_add_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_RADD && dest_file |=>
      {carry_o, fwr_data_o} ==
      9'($past(q.acc) + $past(req_i.fdata))) // RULE7
      else $error("register add sum wrong");

   asr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_ASR && !dest_file |=>
      acc_o == {$past(req_i.fdata[7]), $past(req_i.fdata[7:1])}
      && carry_o == $past(req_i.fdata[0])) // RULE8
      else $error("arithmetic shift wrong");

   addc_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_ADDC && !dest_file |=>
      {carry_o, acc_o} ==
      9'($past(q.acc) + $past(req_i.fdata) + $past(q.c))) // RULE9
      else $error("add with carry wrong");

   no_decode_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && !is_ptradd && !reg_wr_i |=> $stable(q.ptr)) // RULE10
      else $error("pointer changed without pointer add word");

   zero_flag_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op inside {ASALU_OP_LAND, ASALU_OP_LADD}
      |=> zero_o == (acc_o == 8'h00)) // RULE11
      else $error("zero flag disagrees with result");

   half_carry_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op == ASALU_OP_LADD |=> half_carry_o ==
      ((5'($past(q.acc[3:0])) + 5'($past(lit[3:0]))) > 5'h0f)) // RULE11
      else $error("half carry wrong");

   sequence exec_s(asalu_op_t o);
      exec_i && (req_i.op == o);
   endsequence

   sequence rd_req_s(logic [1:0] a);
      reg_rd_i && (reg_addr_i == a);
   endsequence

   // register port: read data stand one cycle, zero otherwise

   rd_acc_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      rd_req_s(REG_ACC) |=> reg_rdata_o == {8'h00, $past(q.acc)})
      else $error("accumulator read data wrong");

   rd_stat_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      rd_req_s(REG_STATUS) |=>
      reg_rdata_o == {13'h0, $past(q.z), $past(q.dc), $past(q.c)})
      else $error("status read data wrong");

   rd_ptr0_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      rd_req_s(REG_PTR0) |=> reg_rdata_o == $past(q.ptr[0])) // RULE1
      else $error("pointer 0 read data wrong");

   rd_ptr1_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      rd_req_s(REG_PTR1) |=> reg_rdata_o == $past(q.ptr[1])) // RULE1
      else $error("pointer 1 read data wrong");

   rd_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data not zero outside a read");

   acc_wr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      acc_wr && !exec_i |=> acc_o == $past(reg_wdata_i[7:0]))
      else $error("accumulator write lost");

   stat_wr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      stat_wr && !exec_i |=> carry_o == $past(reg_wdata_i[STAT_C_BIT])
      && half_carry_o == $past(reg_wdata_i[STAT_DC_BIT])
      && zero_o == $past(reg_wdata_i[STAT_Z_BIT]))
      else $error("status write lost");

   ptr_wr_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_addr_i == REG_PTR0 && !exec_i |=>
      q.ptr[0] == $past(reg_wdata_i))
      else $error("pointer 0 write lost");

   // file write-back port and the remaining destinations

   fwr_idle_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !exec_i |=> !fwr_o) // RULE6
      else $error("file write without an operation");

   lit_dest_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && req_i.op inside {ASALU_OP_LAND, ASALU_OP_LADD}
      |=> !fwr_o) // RULE6
      else $error("literal operation wrote a file register");

   reg_add_acc_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_s(ASALU_OP_RADD) ##0 !dest_file |=>
      {carry_o, acc_o} == 9'($past(q.acc) + $past(req_i.fdata))) // RULE7
      else $error("register add to accumulator wrong");

   asr_file_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_s(ASALU_OP_ASR) ##0 (dest_file && !acc_wr) |=> fwr_o
      && fwr_data_o == {$past(req_i.fdata[7]), $past(req_i.fdata[7:1])}
      && $stable(q.acc)) // RULE8
      else $error("arithmetic shift to file wrong");

   asr_dc_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_s(ASALU_OP_ASR) |=> half_carry_o == $past(dc_keep)) // RULE8
      else $error("arithmetic shift touched half carry");

   addc_file_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_s(ASALU_OP_ADDC) ##0 dest_file |=> {carry_o, fwr_data_o} ==
      9'($past(q.acc) + $past(req_i.fdata) + $past(q.c))) // RULE9
      else $error("add with carry to file wrong");

   reg_zero_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && reg_op |=>
      zero_o == (($past(dest_file) ? fwr_data_o : acc_o) == 8'h00)) // RULE11
      else $error("zero flag disagrees with register result");

   reg_half_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_s(ASALU_OP_RADD) |=> half_carry_o == // RULE11
      ((5'($past(q.acc[3:0])) + 5'($past(req_i.fdata[3:0]))) > 5'h0f))
      else $error("register add half carry wrong");

   addc_half_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_s(ASALU_OP_ADDC) |=> half_carry_o == // RULE11
      ((5'($past(q.acc[3:0])) + 5'($past(req_i.fdata[3:0]))
      + 5'($past(q.c))) > 5'h0f))
      else $error("add with carry half carry wrong");

   ptr_sel_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      exec_i && is_ptradd && !ptr_sel && !reg_wr_i |=>
      $stable(q.ptr[1])) // RULE1
      else $error("unselected pointer changed");
endmodule

// >>> sim/asalu_mem_model.sv
// data memory beside the datapath: 128 file registers, write-back port
// assumes the bench preloads cells through the hierarchy
`timescale 1ns/1ps
module asalu_mem_model (
   input wire logic mclk_i,
   input wire logic [6:0] addr_i,
   input wire logic fwr_i,
   input wire logic [6:0] fwr_addr_i,
   input wire logic [7:0] fwr_data_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [128];
   assign rdata_o = mem[addr_i];
   always @(posedge mclk_i) begin
      if (fwr_i) begin
         mem[fwr_addr_i] <= fwr_data_i;
      end
   end
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the add/and/shift datapath
// assumes the package, the core and the memory model are compiled first
`timescale 1ns/1ps
module tb_top;
   import asalu_pkg::*;
   logic mclk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic exec_i = 1'b0;
   asalu_op_t op_q = ASALU_OP_NONE;
   logic [13:0] instr_q = 14'h0000;
   logic [1:0] ra = 2'h0;
   logic [15:0] wd = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   logic [7:0] acc, fdata, fwd;
   logic c, dc, z, fwr;
   logic [6:0] fwa;
   asalu_req_t req;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   assign req = {op_q, instr_q, fdata};
   always #25 mclk_i = ~mclk_i;
   asalu_core u_asalu_core (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .exec_i(exec_i), .req_i(req), .reg_addr_i(ra), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .acc_o(acc),
      .carry_o(c), .half_carry_o(dc), .zero_o(z), .fwr_o(fwr),
      .fwr_addr_o(fwa), .fwr_data_o(fwd));
   asalu_mem_model u_asalu_mem_model (.mclk_i(mclk_i),
      .addr_i(instr_q[6:0]), .fwr_i(fwr), .fwr_addr_i(fwa),
      .fwr_data_i(fwd), .rdata_o(fdata));
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic rw(logic [1:0] a, logic [15:0] d);
      @(posedge mclk_i);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdchk(logic [1:0] a, logic [15:0] exp);
      @(posedge mclk_i);
      rd <= 1'b1;
      ra <= a;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1;
      chk("reg", exp, rdata);
   endtask
   task automatic ex(asalu_op_t o, logic [13:0] ins);
      @(posedge mclk_i);
      exec_i <= 1'b1;
      op_q <= o;
      instr_q <= ins;
      @(posedge mclk_i);
      exec_i <= 1'b0;
      #1;
   endtask
   task automatic st(logic [7:0] a, logic [2:0] f);
      chk("acc", {8'h00, a}, {8'h00, acc});
      chk("flags", {13'h0, f}, {13'h0, z, dc, c});
   endtask
   // file write pulse, then the cell after the memory takes it
   task automatic fw(logic [6:0] a, logic [7:0] d);
      chk("fwr", {1'b1, a, d}, {fwr, fwa, fwd});
      @(posedge mclk_i);
      #1;
      chk("cell", {8'h00, d}, {8'h00, u_asalu_mem_model.mem[a]});
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 1000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      u_asalu_mem_model.mem[0] = 8'h00;
      u_asalu_mem_model.mem[1] = 8'hff;
      u_asalu_mem_model.mem[2] = 8'h08;
      u_asalu_mem_model.mem[3] = 8'h81;
      u_asalu_mem_model.mem[4] = 8'h3f;
      u_asalu_mem_model.mem[127] = 8'h5a;
      repeat (12) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rdchk(i[1:0], 16'h0000);
      end
      $display("test reset done");
      rw(REG_ACC, 16'h00f0);
      rw(REG_STATUS, 16'h0003);
      ex(ASALU_OP_LAND, 14'h000f);
      st(8'h00, 3'b111);
      rw(REG_STATUS, 16'h0000);
      rw(REG_ACC, 16'h008f);
      ex(ASALU_OP_LADD, 14'h0071);
      st(8'h00, 3'b111);
      ex(ASALU_OP_LADD, 14'h0092);
      st(8'h92, 3'b000);
      $display("test literal done");
      ex(ASALU_OP_RAND, 14'h00ff);
      st(8'h92, 3'b000);
      fw(7'h7f, 8'h12);
      ex(ASALU_OP_RAND, 14'h0000);
      st(8'h00, 3'b100);
      rw(REG_ACC, 16'h0001);
      ex(ASALU_OP_RADD, 14'h0001);
      st(8'h00, 3'b111);
      // nonzero accumulator so the written cell differs from its old value
      rw(REG_ACC, 16'h0005);
      ex(ASALU_OP_RADD, 14'h0082);
      st(8'h05, 3'b000);
      fw(7'h02, 8'h0d);
      $display("test register done");
      ex(ASALU_OP_ASR, 14'h0082);
      st(8'h05, 3'b001);
      fw(7'h02, 8'h06);
      ex(ASALU_OP_ASR, 14'h0003);
      st(8'hc0, 3'b001);
      ex(ASALU_OP_ADDC, 14'h0084);
      st(8'hc0, 3'b111);
      fw(7'h04, 8'h00);
      ex(ASALU_OP_ADDC, 14'h0002);
      st(8'hc7, 3'b000);
      $display("test shift and carry done");
      rw(REG_PTR0, 16'hffff);
      ex(ASALU_OP_NONE, {7'h62, 1'b0, 6'h01});
      rw(REG_PTR1, 16'h0010);
      ex(ASALU_OP_NONE, {7'h62, 1'b1, 6'h20});
      ex(ASALU_OP_NONE, {7'h63, 1'b0, 6'h1f});
      rdchk(REG_PTR0, 16'h0000);
      rdchk(REG_PTR1, 16'hfff0);
      ex(ASALU_OP_NONE, {7'h62, 1'b1, 6'h1f});
      rdchk(REG_PTR1, 16'h000f);
      st(8'hc7, 3'b000);
      $display("test pointer done");
      // mid-run reset must clear accumulator, flags and both pointers again; the file cells keep their values
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      st(8'h00, 3'b000);
      for (int i = 0; i < 4; i++) begin
         rdchk(i[1:0], 16'h0000);
      end
      $display("test second reset done");
      print_verdict();
   end
endmodule
